// ==== gbm_pkg.sv ====
package gbm_pkg;
  // Address and register window geometry
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int WIN_W = 7;
  localparam int BASE_W = ADDR_W - WIN_W;
  // Register offsets
  localparam logic [6:0] OFF_BASE = 7'h00;
  localparam logic [6:0] OFF_BIU_LAST = 7'h0F;
  localparam logic [6:0] OFF_DISP_PRI = 7'h0A;
  localparam logic [6:0] OFF_GFX_PRI = 7'h0C;
  localparam logic [6:0] OFF_EXT_PRI = 7'h0E;
  // Priority register fields: first level high, continuing level low
  localparam int PRI_FIRST_LSB = 3;
  localparam int PRI_CONT_LSB = 0;
  // Base register field layout
  localparam int BASE_MEM_BIT = 0;
  localparam int BASE_ADDR_LSB = 1;
  localparam logic [15:0] BASE_RESET = 16'h0000;
  // Top of the engine address space
  localparam logic [21:0] ADDR_TOP = 22'h3F_FFFF;
  // Priority resets
  localparam logic [2:0] PRI_MAX = 3'h7;
  localparam logic [2:0] DISP_FIRST_RST = 3'h6;
  localparam logic [2:0] DISP_CONT_RST = 3'h3;
  localparam logic [2:0] GFX_FIRST_RST = 3'h5;
  localparam logic [2:0] GFX_CONT_RST = 3'h2;
  localparam logic [2:0] EXT_FIRST_RST = 3'h7;
  // Bus owner
  typedef enum logic [2:0] {
    OWN_IDLE, OWN_REFRESH, OWN_DISP, OWN_GFX, OWN_EXT
  } gbm_owner_t;
endpackage

// ==== gbm_bus_interface_unit.sv ====
`timescale 1ns/1ps
// Operation
// - Engines issue memory-only 22-bit accesses
// - Local memory spans zero to configured limit
// - Engine addresses above limit go to system
// - Slave writes above memory are dropped
// - Memory-mapped register window overrides memory for CPU
// - Engine accesses in window reach memory
// - Registers reachable only by CPU slave
// - Ignore chip-select while bus master
// - Configuration registers sit at offsets 0-15
// - Base holds bits 21:7 plus space flag
// - Before base write, all I/O hits registers
// - After base write, only programmed window
// - Match uses device address pins directly
// - Arbiter takes four request sources
// - Refresh wins after current access ends
// - First request competes at first priority
// - Block owner holds, regains at continuing priority
// - Priorities 0-7, ties display then graphics; external beats both
// - Higher request suspends block transfer
// - CPU slave beats pending engine master
module gbm_bus_interface_unit
  import gbm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // Configured local memory size in bytes, as an end address
  input wire logic [gbm_pkg::ADDR_W-1:0] memLimit,
  // Engine address from the current bus owner
  input wire logic [gbm_pkg::ADDR_W-1:0] engineAddr,
  output logic engineToSystem,
  output logic engineToLocal,
  // CPU slave port on the device pins
  input wire logic chipSelect_n,
  input wire logic memSpace,
  input wire logic slaveWrite,
  input wire logic slaveStrobe,
  input wire logic [gbm_pkg::ADDR_W-1:0] slaveAddr,
  input wire logic [gbm_pkg::DATA_W-1:0] slaveWdata,
  output logic [gbm_pkg::DATA_W-1:0] slaveRdata,
  output logic slaveToRegs,
  output logic slaveToMemory,
  output logic slaveWriteDropped,
  input wire logic masterActive,
  // Requests and block-transfer state
  input wire logic refreshReq,
  input wire logic displayReq,
  input wire logic graphicsReq,
  input wire logic displayBlock,
  input wire logic graphicsBlock,
  input wire logic accessDone,
  output logic grantRefresh,
  output logic grantDisplay,
  output logic grantGraphics,
  output logic grantExternal
);
  import gbm_pkg::*;

  // Pin synchronisers for the slave strobe, select, master flag
  logic [1:0] syncStrobe;
  logic [1:0] syncCs;
  logic [1:0] syncMaster;
  logic [1:0] syncSpace; // Memory or I/O space pin
  logic [1:0] syncWrite; // Write direction pin
  // Address and data words pass two stages as well; they are only
  // used when the strobe edge has passed the same depth, and the
  // host holds them steady for the whole strobe. A real host should
  // settle them a cycle before raising the strobe.
  logic [ADDR_W-1:0] addrMeta; // First stage, read by the second only
  logic [ADDR_W-1:0] addrPin; // Settled address from the pins
  logic [DATA_W-1:0] wdataMeta; // First stage of the write data
  logic [DATA_W-1:0] wdataPin; // Settled write data
  logic strobeSeen;
  logic slaveReq;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncStrobe <= 2'h0;
      syncCs <= 2'h0;
      syncMaster <= 2'h0;
      syncSpace <= 2'h0;
      syncWrite <= 2'h0;
      addrMeta <= 22'h00_0000;
      addrPin <= 22'h00_0000;
      wdataMeta <= 16'h0000;
      wdataPin <= 16'h0000;
    end else begin
      syncStrobe <= {syncStrobe[0], slaveStrobe};
      syncCs <= {syncCs[0], ~chipSelect_n};
      syncMaster <= {syncMaster[0], masterActive};
      syncSpace <= {syncSpace[0], memSpace};
      syncWrite <= {syncWrite[0], slaveWrite};
      addrMeta <= slaveAddr;
      addrPin <= addrMeta;
      wdataMeta <= slaveWdata;
      wdataPin <= wdataMeta;
    end
  end

  // Edge memory for the strobe, read from the second stage only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strobeSeen <= 1'b0;
    end else begin
      strobeSeen <= syncStrobe[1];
    end
  end

  // Chip select is disregarded while we own the system bus
  assign slaveReq = syncStrobe[1] & ~strobeSeen & syncCs[1]
                    & ~syncMaster[1];

  // Register storage: base plus the priority registers
  logic [15:0] baseReg;
  logic baseWritten;
  logic [2:0] dispFirst;
  logic [2:0] dispCont;
  logic [2:0] gfxFirst;
  logic [2:0] gfxCont;
  logic [2:0] extFirst;

  // Window decode on the device's own pins, not the CPU address
  logic winHit;
  logic regHit;
  logic aboveMem;
  always_comb begin
    winHit = (addrPin[ADDR_W-1:WIN_W]
              == baseReg[BASE_ADDR_LSB +: BASE_W])
             && (syncSpace[1] == baseReg[BASE_MEM_BIT]);
    if (!baseWritten) begin
      // Whole I/O space answers until a base is programmed
      regHit = ~syncSpace[1];
    end else begin
      regHit = winHit;
    end
    aboveMem = addrPin > memLimit;
  end

  // Slave data paths are sampled once per synchronised strobe
  logic [6:0] regOff;
  assign regOff = addrPin[WIN_W-1:0];

  // Routing flags held until the next slave access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slaveToRegs <= 1'b0;
      slaveToMemory <= 1'b0;
      slaveWriteDropped <= 1'b0;
    end else if (slaveReq) begin
      // Registers win over memory, engines never see this path
      slaveToRegs <= regHit;
      slaveToMemory <= ~regHit & syncSpace[1] & ~aboveMem;
      slaveWriteDropped <= ~regHit & syncSpace[1] & aboveMem
                           & syncWrite[1];
    end
  end

  // Register writes; only the configuration range exists here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baseReg <= BASE_RESET;
      baseWritten <= 1'b0;
      dispFirst <= DISP_FIRST_RST;
      dispCont <= DISP_CONT_RST;
      gfxFirst <= GFX_FIRST_RST;
      gfxCont <= GFX_CONT_RST;
      extFirst <= EXT_FIRST_RST;
    end else if (slaveReq && regHit && syncWrite[1]
                 && regOff <= OFF_BIU_LAST) begin
      unique case (regOff)
        OFF_DISP_PRI: begin
          dispFirst <= wdataPin[PRI_FIRST_LSB +: 3];
          dispCont <= wdataPin[PRI_CONT_LSB +: 3];
        end
        OFF_GFX_PRI: begin
          gfxFirst <= wdataPin[PRI_FIRST_LSB +: 3];
          gfxCont <= wdataPin[PRI_CONT_LSB +: 3];
        end
        // The external requester never bursts, so it has no second level
        OFF_EXT_PRI: extFirst <= wdataPin[PRI_FIRST_LSB +: 3];
        OFF_BASE: begin
          baseReg <= wdataPin;
          baseWritten <= 1'b1;
        end
        default: ; // Other configuration offsets hold nothing here
      endcase
    end
  end

  // Packs a priority pair into its register word, reserved bits zero
  function automatic logic [DATA_W-1:0] packPri(input logic [2:0] first,
                                               input logic [2:0] cont);
    logic [DATA_W-1:0] value;
    value = 16'h0000;
    value[PRI_FIRST_LSB +: 3] = first;
    value[PRI_CONT_LSB +: 3] = cont;
    packPri = value;
  endfunction

  // Read data; unmapped offsets and memory reads return zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slaveRdata <= 16'h0000;
    end else if (slaveReq && !syncWrite[1]) begin
      if (!regHit || regOff > OFF_BIU_LAST) begin
        slaveRdata <= 16'h0000;
      end else begin
        unique case (regOff)
          OFF_BASE: slaveRdata <= baseReg;
          OFF_DISP_PRI: slaveRdata <= packPri(dispFirst, dispCont);
          OFF_GFX_PRI: slaveRdata <= packPri(gfxFirst, gfxCont);
          OFF_EXT_PRI: slaveRdata <= packPri(extFirst, 3'h0);
          default: slaveRdata <= 16'h0000;
        endcase
      end
    end
  end

  // Engine routing: memory only, window ignored for engines
  always_comb begin
    engineToLocal = engineAddr <= memLimit;
    engineToSystem = (engineAddr > memLimit)
                     && (engineAddr <= ADDR_TOP);
  end

  // External request latched until served
  logic extPending;
  gbm_owner_t owner;
  gbm_owner_t next_owner;
  logic dispSuspended;
  logic gfxSuspended;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extPending <= 1'b0;
    end else if (slaveReq && syncCs[1]) begin
      extPending <= 1'b1;
    end else if (owner == OWN_EXT && accessDone) begin
      extPending <= 1'b0;
    end
  end

  // Effective priority: continuing level while holding or resuming
  function automatic logic [2:0] effPri(input logic [2:0] first,
                                        input logic [2:0] cont,
                                        input logic useCont);
    effPri = useCont ? cont : first;
  endfunction

  logic [2:0] dispPri;
  logic [2:0] gfxPri;
  logic dispHold;
  logic gfxHold;
  always_comb begin
    dispHold = (owner == OWN_DISP && displayBlock) || dispSuspended;
    gfxHold = (owner == OWN_GFX && graphicsBlock) || gfxSuspended;
    dispPri = effPri(dispFirst, dispCont, dispHold);
    gfxPri = effPri(gfxFirst, gfxCont, gfxHold);
  end

  // A served external access must not win again on its own closing
  // edge: the pending flag only clears there, so it is masked here
  logic extWants;
  assign extWants = extPending & ~((owner == OWN_EXT) & accessDone);

  // Arbitration at access boundaries only
  always_comb begin
    next_owner = owner;
    if (owner == OWN_IDLE || accessDone) begin
      if (refreshReq) begin
        next_owner = OWN_REFRESH;
      end else if (extWants && (displayReq || graphicsReq)) begin
        // Host first, or it could stall waiting on us while we wait on it
        next_owner = OWN_EXT;
      end else if (displayReq && (!graphicsReq || dispPri >= gfxPri)
                   && (!extWants || dispPri >= extFirst)) begin
        next_owner = OWN_DISP;
      end else if (graphicsReq && (!extWants || gfxPri >= extFirst)) begin
        next_owner = OWN_GFX;
      end else if (extWants) begin
        next_owner = OWN_EXT;
      end else begin
        next_owner = OWN_IDLE;
      end
    end
  end

  // Owner register and suspension memory
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      owner <= OWN_IDLE;
      dispSuspended <= 1'b0;
      gfxSuspended <= 1'b0;
    end else begin
      owner <= next_owner;
      if (owner == OWN_DISP && displayBlock && next_owner != OWN_DISP) begin
        dispSuspended <= 1'b1;
      end else if (next_owner == OWN_DISP || !displayReq) begin
        dispSuspended <= 1'b0;
      end
      if (owner == OWN_GFX && graphicsBlock && next_owner != OWN_GFX) begin
        gfxSuspended <= 1'b1;
      end else if (next_owner == OWN_GFX || !graphicsReq) begin
        gfxSuspended <= 1'b0;
      end
    end
  end

  // Grants follow the owner register
  assign grantRefresh = owner == OWN_REFRESH;
  assign grantDisplay = owner == OWN_DISP;
  assign grantGraphics = owner == OWN_GFX;
  assign grantExternal = owner == OWN_EXT;
endmodule // gbm_bus_interface_unit

// ==== gbm_checker.sv ====
`timescale 1ns/1ps
// Watches routing, slave flags and grants at the unit's pins
module gbm_checker
  import gbm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [gbm_pkg::ADDR_W-1:0] memLimit,
  input wire logic [gbm_pkg::ADDR_W-1:0] engineAddr,
  input wire logic engineToSystem,
  input wire logic engineToLocal,
  input wire logic slaveStrobe,
  input wire logic [gbm_pkg::DATA_W-1:0] slaveRdata,
  input wire logic slaveToRegs,
  input wire logic slaveToMemory,
  input wire logic slaveWriteDropped,
  input wire logic refreshReq,
  input wire logic accessDone,
  input wire logic grantRefresh,
  input wire logic grantDisplay,
  input wire logic grantGraphics,
  input wire logic grantExternal
);
  // Grants gathered so one compare covers the owner
  logic [3:0] grants;
  assign grants = {grantRefresh, grantDisplay, grantGraphics, grantExternal};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_local_route: assert property (
    engineToLocal == (engineAddr <= memLimit)) else $error("local route");
  a_system_route: assert property (
    engineToSystem == (engineAddr > memLimit)) else $error("system route");
  a_grant_onehot: assert property ($onehot0(grants))
    else $error("two grants");
  a_refresh_first: assert property (
    refreshReq && (accessDone || grants == 4'h0) |=> grantRefresh)
    else $error("refresh not next");
  a_grant_hold: assert property (
    (|grants) && !accessDone |=> $stable(grants)) else $error("owner lost");
  a_drop_alone: assert property (
    slaveWriteDropped |-> !slaveToMemory && !slaveToRegs)
    else $error("dropped write routed");
  a_regs_over_mem: assert property (!(slaveToRegs && slaveToMemory))
    else $error("regs and memory");
  // Without a strobe rise nothing was accepted, so flags stand
  a_flags_stand: assert property (!slaveStrobe [*5] |=>
    $stable({slaveToRegs, slaveToMemory, slaveWriteDropped, slaveRdata}))
    else $error("flags moved");
endmodule // gbm_checker

// ==== gbm_host_model.sv ====
`timescale 1ns/1ps
// Host processor doing slave cycles on the unit's pins
module gbm_host_model (
  input wire logic clk,
  output logic chipSelect_n,
  output logic memSpace,
  output logic slaveWrite,
  output logic slaveStrobe,
  output logic [21:0] slaveAddr,
  output logic [15:0] slaveWdata
);
  // Idle bus: deselected, strobe low
  initial begin
    chipSelect_n = 1'b1;
    {memSpace, slaveWrite, slaveStrobe} = 3'b000;
    slaveAddr = 22'h00_0000;
    slaveWdata = 16'h0000;
  end
  // Strobe held past the answer, then a gap longer than two cycles
  task automatic access(input logic m, input logic w,
    input logic [21:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    chipSelect_n = 1'b0;
    {memSpace, slaveWrite} = {m, w};
    slaveAddr = a;
    slaveWdata = d;
    slaveStrobe = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    slaveStrobe = 1'b0;
    chipSelect_n = 1'b1;
    // Released lines show junk, never the last value
    slaveAddr = ~a;
    slaveWdata = ~d;
    repeat (3) @(posedge clk);
  endtask
endmodule // gbm_host_model

// ==== graphics_bus_address_map_and_priority_bench.sv ====
`timescale 1ns/1ps
module graphics_bus_address_map_and_priority_bench;
  import gbm_pkg::*;
  logic clk = 0, rst = 1, masterActive = 0, accessDone = 0;
  logic refreshReq = 0, displayReq = 0, graphicsReq = 0;
  logic displayBlock = 0, graphicsBlock = 0;
  logic [21:0] memLimit = 22'h0F_FFFF, engineAddr = 22'h00_0000;
  logic chipSelect_n, memSpace, slaveWrite, slaveStrobe;
  logic [21:0] slaveAddr;
  logic [15:0] slaveWdata, slaveRdata;
  logic slaveToRegs, slaveToMemory, slaveWriteDropped, engineToSystem;
  logic engineToLocal, grantRefresh, grantDisplay, grantGraphics;
  logic grantExternal;
  int fail_count = 0, cmp_count = 0;
  // Rows: engine address, expected local routing
  logic [22:0] rows [4] = '{{22'h00_0000, 1'b1}, {22'h0F_FFFF, 1'b1},
    {22'h10_0000, 1'b0}, {22'h3F_FFFF, 1'b0}};
  logic [15:0] prio [3] = '{16'h0033, 16'h002A, 16'h0038};
  always #25 clk = ~clk;
  gbm_host_model i_host (.clk(clk), .chipSelect_n(chipSelect_n),
    .memSpace(memSpace), .slaveWrite(slaveWrite), .slaveStrobe(slaveStrobe),
    .slaveAddr(slaveAddr), .slaveWdata(slaveWdata));
  gbm_bus_interface_unit i_dut (.clk(clk), .rst(rst), .memLimit(memLimit),
    .engineAddr(engineAddr), .engineToSystem(engineToSystem),
    .engineToLocal(engineToLocal), .chipSelect_n(chipSelect_n),
    .memSpace(memSpace), .slaveWrite(slaveWrite), .slaveStrobe(slaveStrobe),
    .slaveAddr(slaveAddr), .slaveWdata(slaveWdata), .slaveRdata(slaveRdata),
    .slaveToRegs(slaveToRegs), .slaveToMemory(slaveToMemory),
    .slaveWriteDropped(slaveWriteDropped), .masterActive(masterActive),
    .refreshReq(refreshReq), .displayReq(displayReq),
    .graphicsReq(graphicsReq), .displayBlock(displayBlock),
    .graphicsBlock(graphicsBlock), .accessDone(accessDone),
    .grantRefresh(grantRefresh), .grantDisplay(grantDisplay),
    .grantGraphics(grantGraphics), .grantExternal(grantExternal));
  // Compare with case inequality so unknowns count as misses
  task automatic chk(input string n, input logic [15:0] e,
    input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // One arbiter cycle: drive requests, let the owner edge land
  task automatic step(input logic [3:0] r, input logic [3:0] eg);
    {refreshReq, displayReq, graphicsReq, accessDone} = r;
    @(posedge clk);
    #1;
    chk("grants", {12'h000, eg}, {12'h000, grantRefresh, grantDisplay,
      grantGraphics, grantExternal});
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    foreach (rows[i]) begin
      @(posedge clk);
      #1;
      engineAddr = rows[i][22:1];
      #1;
      chk("local", {15'h0, rows[i][0]}, {15'h0, engineToLocal});
      chk("system", {15'h0, !rows[i][0]}, {15'h0, engineToSystem});
    end
    $display("routing test done");
    repeat (16) @(posedge clk);
    chk("regs in reset", 16'h0000, {15'h0, slaveToRegs});
    #1;
    rst = 0;
    // Unwritten base: any I/O address reaches the registers
    foreach (prio[i]) begin
      i_host.access(1'b0, 1'b0, 22'h12_340A + 22'(2 * i), 16'h0000);
      chk("priority reset", prio[i], slaveRdata);
    end
    i_host.access(1'b0, 1'b1, 22'h00_0000, 16'h0041);
    i_host.access(1'b1, 1'b0, 22'h00_100A, 16'h0000);
    chk("mem window", 16'h0033, slaveRdata);
    chk("mem window regs", 16'h0001, {15'h0, slaveToRegs});
    i_host.access(1'b1, 1'b0, 22'h00_1000, 16'h0000);
    chk("base readback", 16'h0041, slaveRdata);
    i_host.access(1'b0, 1'b0, 22'h12_340A, 16'h0000);
    chk("io after base", 16'h0000, {15'h0, slaveToRegs});
    i_host.access(1'b1, 1'b0, 22'h00_200A, 16'h0000);
    chk("plain memory", 16'h0001, {15'h0, slaveToMemory});
    i_host.access(1'b1, 1'b1, 22'h20_0000, 16'h1234);
    chk("write dropped", 16'h0001, {15'h0, slaveWriteDropped});
    #1;
    masterActive = 1'b1;
    repeat (3) @(posedge clk);
    i_host.access(1'b1, 1'b0, 22'h00_100A, 16'h0000);
    chk("master ignores", 16'h0001, {15'h0, slaveWriteDropped});
    chk("master no regs", 16'h0000, {15'h0, slaveToRegs});
    #1;
    masterActive = 1'b0;
    $display("slave test done");
    // The slave accesses left the external requester owning the bus
    step(4'b0001, 4'b0000);
    step(4'b0110, 4'b0100);
    step(4'b1110, 4'b0100);
    step(4'b1111, 4'b1000);
    step(4'b0111, 4'b0100);
    step(4'b0011, 4'b0010);
    step(4'b0001, 4'b0000);
    step(4'b0000, 4'b0000);
    $display("arbiter test done");
    // Display 4/4 and external 0, so continuing levels decide below
    i_host.access(1'b1, 1'b1, 22'h00_100A, 16'h0024);
    i_host.access(1'b1, 1'b1, 22'h00_100E, 16'h0000);
    i_host.access(1'b1, 1'b0, 22'h00_100A, 16'h0000);
    chk("disp priority", 16'h0024, slaveRdata);
    #1;
    step(4'b0001, 4'b0000);
    graphicsBlock = 1'b1;
    step(4'b0010, 4'b0010);
    step(4'b0111, 4'b0100);
    step(4'b0111, 4'b0100);
    step(4'b0011, 4'b0010);
    step(4'b0010, 4'b0010);
    i_host.access(1'b1, 1'b0, 22'h00_2000, 16'h0000);
    #1;
    step(4'b0011, 4'b0001);
    step(4'b0011, 4'b0010);
    graphicsBlock = 1'b0;
    step(4'b0001, 4'b0000);
    $display("block test done");
    tally_and_finish();
  end
endmodule // graphics_bus_address_map_and_priority_bench
bind gbm_bus_interface_unit gbm_checker i_chk (.clk(clk), .rst(rst),
  .memLimit(memLimit), .engineAddr(engineAddr),
  .engineToSystem(engineToSystem), .engineToLocal(engineToLocal),
  .slaveStrobe(slaveStrobe), .slaveRdata(slaveRdata),
  .slaveToRegs(slaveToRegs), .slaveToMemory(slaveToMemory),
  .slaveWriteDropped(slaveWriteDropped), .refreshReq(refreshReq),
  .accessDone(accessDone), .grantRefresh(grantRefresh),
  .grantDisplay(grantDisplay), .grantGraphics(grantGraphics),
  .grantExternal(grantExternal));
